// ---- hw/muc_map.svh ----
`ifndef MUC_MAP_SVH
`define MUC_MAP_SVH

// ram geometry: 16 Mbyte transmit, 8 Mbyte receive, 32-bit words
`define MUC_TX_AW        22
`define MUC_RX_AW        21
`define MUC_CNT_W        16

// oversampling: sixteen reference ticks per serial bit
`define MUC_TICK_LAST    4'hF
`define MUC_TICK_MID     4'h7
`define MUC_DATA_LAST    3'h7
`define MUC_LANE_LAST    2'h3

// end of message after eight idle bit periods (8 x 16 ticks)
`define MUC_IDLE_BITS    8
`define MUC_IDLE_LAST    8'h7F

// receive status word layout
`define MUC_STAT_CNT_LSB  0
`define MUC_STAT_NEXT_LSB 16

// reset values
`define MUC_LINE_IDLE    1'b1
`define MUC_SYNC_IDLE    2'h3

`endif

// ---- hw/muc_pkg.sv ----
package muc_pkg;

  // transmit sequence, gray coded along the usual path
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h0,
    TX_LOAD  = 3'h1,
    TX_START = 3'h3,
    TX_DATA  = 3'h2,
    TX_PAR   = 3'h6,
    TX_STOP  = 3'h7
  } muc_tx_t;

  // receive sequence, gray coded along the usual path
  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h3,
    RX_PAR   = 3'h2,
    RX_STOP  = 3'h6,
    RX_FLUSH = 3'h7,
    RX_STAT  = 3'h5
  } muc_rx_t;

  // parity selection encoding
  typedef enum logic [1:0] {
    PAR_ODD   = 2'h0,
    PAR_EVEN  = 2'h1,
    PAR_MARK  = 2'h2,
    PAR_SPACE = 2'h3
  } muc_par_t;

  // whole register state of one channel
  typedef struct packed {
    logic [1:0]  refSync;
    logic        refPrev;
    logic [1:0]  rxSync;
    logic [1:0]  lineSync;
    logic        txEnPrev;
    logic        rxEnPrev;
    muc_tx_t     txState;
    logic [3:0]  txTick;
    logic [2:0]  txBit;
    logic [1:0]  txLane;
    logic        txStop2;
    logic [21:0] txAddr;
    logic [15:0] txLeft;
    logic [31:0] txWord;
    logic [7:0]  txShift;
    logic        txPar;
    logic        txLine;
    logic        txDone;
    muc_rx_t     rxState;
    logic [3:0]  rxTick;
    logic [2:0]  rxBit;
    logic [7:0]  rxShift;
    logic        rxPar;
    logic [7:0]  rxIdle;
    logic        rxInMsg;
    logic [20:0] rxBase;
    logic [20:0] rxPtr;
    logic [31:0] rxWord;
    logic [15:0] rxCount;
    logic [15:0] rxLastCount;
    logic        rxDone;
    logic        parityErr;
    logic        frameErr;
  } muc_state_t;

endpackage

// ---- hw/muc_channel.sv ----
// Functional notes
// - characters go LSB first, one low start bit, one or two high stops.
// - optional parity after eight data bits: odd, even, mark or space.
// - serial line rests high whenever no character is being sent.
// - every message starts on a 32-bit word boundary in its ram.
// - unsent bytes of the last transmit word are skipped.
// - unfilled byte lanes of the last received word are written zero.
// - half or full duplex is chosen per channel.
// - half duplex: receiver listens on transmit line, driver released while idle.
// - 16 Mbyte transmit ram, 8 Mbyte receive ram, host word access.
// - dma writes transmit ram and reads receive ram.
// - separate programmable start offsets for transmitter and receiver.
// - transmitter reads words upward from start, LSB first, until count.
// - every re-enable while idle with a nonzero count restarts transmission from the same start offset.
// - receive data begins one word after the start offset.
// - finished message gets status word (count, next start) in first slot.
// - next message is stored right after the previous one.
// - bit timing comes from the link reference clock, 16 ticks per bit.
// - discrete i/o timing belongs to a separate clock, not this block.
// - eight idle bit periods end a message: count, status, done flag.
// - first byte of four goes to the least significant byte lane.
// - 16-bit counter counts each received data byte of a message.
`include "muc_map.svh"
`timescale 1ns/1ps
`default_nettype none

module muc_channel #(
  parameter int TX_AW = `MUC_TX_AW,
  parameter int RX_AW = `MUC_RX_AW
) (
  // clock and reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // link reference, sixteen ticks per bit
  input  wire logic                wordUartRef,
  // serial pins
  output logic                     serTxOut,
  output logic                     serTxOe,
  input  wire logic                serTxIn,
  input  wire logic                serRxIn,
  // line configuration
  input  wire logic                halfDuplex,
  input  wire logic                stopTwo,
  input  wire logic                parityEn,
  input  wire muc_pkg::muc_par_t   paritySel,
  // transmitter control and status
  input  wire logic                txEnable,
  input  wire logic [TX_AW-1:0]    txStart,
  input  wire logic [15:0]         txByteCount,
  output logic                     txBusy,
  output logic                     txDone,
  // receiver control and status
  input  wire logic                rxEnable,
  input  wire logic [RX_AW-1:0]    rxStart,
  input  wire logic                rxStatusClr,
  output logic                     rxDone,
  output logic                     rxParityErr,
  output logic                     rxFrameErr,
  output logic [15:0]              rxByteCount,
  output logic [15:0]              rxMsgCount,
  // host word access to transmit ram
  input  wire logic                hostTxWe,
  input  wire logic [TX_AW-1:0]    hostTxAddr,
  input  wire logic [31:0]         hostTxWdata,
  output logic [31:0]              hostTxRdata,
  // host word access to receive ram
  input  wire logic                hostRxWe,
  input  wire logic [RX_AW-1:0]    hostRxAddr,
  input  wire logic [31:0]         hostRxWdata,
  output logic [31:0]              hostRxRdata,
  // dma write into transmit ram
  input  wire logic                dmaTxWe,
  input  wire logic [TX_AW-1:0]    dmaTxAddr,
  input  wire logic [31:0]         dmaTxWdata,
  // dma read from receive ram
  input  wire logic [RX_AW-1:0]    dmaRxAddr,
  output logic [31:0]              dmaRxRdata
);
  import muc_pkg::*;

  muc_state_t         s;
  muc_state_t         next_s;
  logic [31:0]        txRam [0:(1<<TX_AW)-1];
  logic [31:0]        rxRam [0:(1<<RX_AW)-1];
  logic               tick;
  logic               txBitEnd;
  logic               rxSample;
  logic               rxLine;
  logic [31:0]        txFetch;
  logic [31:0]        rxWordNew;
  logic               rxWe;
  logic [RX_AW-1:0]   rxWa;
  logic [31:0]        rxWd;

  // parity bit from the xor of the data bits
  function automatic logic parBit(input muc_par_t sel, input logic x);
    case (sel)
      PAR_ODD:  parBit = ~x;
      PAR_EVEN: parBit = x;
      PAR_MARK: parBit = 1'b1;
      default:  parBit = 1'b0;
    endcase
  endfunction

  // reference tick and sampled receive line
  assign tick     = s.refSync[1] & ~s.refPrev;
  assign rxLine   = halfDuplex ? s.lineSync[1] : s.rxSync[1];
  assign txBitEnd = tick && (s.txTick == `MUC_TICK_LAST);
  assign rxSample = tick && (s.rxTick == `MUC_TICK_LAST);
  assign txFetch  = txRam[s.txAddr[TX_AW-1:0]];
  assign rxWordNew = s.rxWord |
    ({24'h000000, s.rxShift} << {s.rxCount[1:0], 3'h0});

  // outputs
  assign serTxOut    = s.txLine;
  assign serTxOe     = ~halfDuplex | (s.txState != TX_IDLE);
  assign txBusy      = (s.txState != TX_IDLE);
  assign txDone      = s.txDone;
  assign rxDone      = s.rxDone;
  assign rxParityErr = s.parityErr;
  assign rxFrameErr  = s.frameErr;
  assign rxByteCount = s.rxLastCount;
  assign rxMsgCount  = s.rxCount;

  // next state of the whole channel
  always_comb begin
    next_s          = s;
    rxWe            = 1'b0;
    rxWa            = s.rxPtr[RX_AW-1:0];
    rxWd            = s.rxWord;
    next_s.refSync  = {s.refSync[0], wordUartRef};
    next_s.refPrev  = s.refSync[1];
    next_s.rxSync   = {s.rxSync[0], serRxIn};
    next_s.lineSync = {s.lineSync[0], serTxIn};
    next_s.txEnPrev = txEnable;
    next_s.rxEnPrev = rxEnable;
    next_s.txDone   = 1'b0;
    if (tick && s.txState != TX_IDLE && s.txState != TX_LOAD) begin
      next_s.txTick = s.txTick + 4'h1;
    end

    // transmitter
    case (s.txState)
      TX_IDLE: begin
        if (txEnable && !s.txEnPrev && txByteCount != 16'h0000) begin
          next_s.txAddr  = 22'(txStart);
          next_s.txLeft  = txByteCount;
          next_s.txState = TX_LOAD;
        end
      end
      TX_LOAD: begin
        next_s.txWord  = txFetch;
        next_s.txShift = txFetch[7:0];
        next_s.txAddr  = s.txAddr + 22'h1;
        next_s.txLane  = 2'h0;
        next_s.txTick  = 4'h0;
        next_s.txState = TX_START;
      end
      TX_START: begin
        if (txBitEnd) begin
          next_s.txBit   = 3'h0;
          next_s.txPar   = 1'b0;
          next_s.txState = TX_DATA;
        end
      end
      TX_DATA: begin
        if (txBitEnd) begin
          next_s.txPar   = s.txPar ^ s.txShift[0];
          next_s.txShift = {1'b0, s.txShift[7:1]};
          next_s.txBit   = s.txBit + 3'h1;
          next_s.txStop2 = 1'b0;
          if (s.txBit == `MUC_DATA_LAST) begin
            next_s.txState = parityEn ? TX_PAR : TX_STOP;
          end
        end
      end
      TX_PAR: begin
        if (txBitEnd) begin
          next_s.txState = TX_STOP;
        end
      end
      TX_STOP: begin
        if (txBitEnd) begin
          if (stopTwo && !s.txStop2) begin
            next_s.txStop2 = 1'b1;
          end else if (s.txLeft == 16'h0001) begin
            next_s.txLeft  = 16'h0000;
            next_s.txDone  = 1'b1;
            next_s.txState = TX_IDLE;
          end else if (s.txLane == `MUC_LANE_LAST) begin
            next_s.txLeft  = s.txLeft - 16'h0001;
            next_s.txState = TX_LOAD;
          end else begin
            next_s.txLeft  = s.txLeft - 16'h0001;
            next_s.txLane  = s.txLane + 2'h1;
            next_s.txShift = 8'(s.txWord >> {s.txLane + 2'h1, 3'h0});
            next_s.txState = TX_START;
          end
        end
      end
      default: next_s.txState = TX_IDLE;
    endcase

    // line level follows the state being entered
    case (next_s.txState)
      TX_START: next_s.txLine = 1'b0;
      TX_DATA:  next_s.txLine = next_s.txShift[0];
      TX_PAR:   next_s.txLine = parBit(paritySel, next_s.txPar);
      default:  next_s.txLine = `MUC_LINE_IDLE;
    endcase

    // receiver
    if (tick && s.rxState != RX_IDLE) begin
      next_s.rxTick = s.rxTick + 4'h1;
    end
    case (s.rxState)
      RX_IDLE: begin
        if (rxEnable && !s.rxEnPrev && !s.rxInMsg) begin
          next_s.rxBase  = 21'(rxStart);
          next_s.rxPtr   = 21'(rxStart) + 21'h1;
          next_s.rxCount = 16'h0000;
          next_s.rxWord  = 32'h00000000;
        end else if (tick && rxEnable && !rxLine) begin
          next_s.rxTick  = 4'h0;
          next_s.rxState = RX_START;
        end else if (tick && s.rxInMsg) begin
          next_s.rxIdle = s.rxIdle + 8'h01;
          if (s.rxIdle == `MUC_IDLE_LAST) begin
            next_s.rxState = (s.rxCount[1:0] != 2'h0) ? RX_FLUSH
                                                      : RX_STAT;
          end
        end
      end
      RX_START: begin
        if (tick && s.rxTick == `MUC_TICK_MID) begin
          next_s.rxTick  = 4'h0;
          next_s.rxBit   = 3'h0;
          next_s.rxPar   = 1'b0;
          next_s.rxState = rxLine ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rxSample) begin
          next_s.rxShift = {rxLine, s.rxShift[7:1]};
          next_s.rxPar   = s.rxPar ^ rxLine;
          next_s.rxBit   = s.rxBit + 3'h1;
          if (s.rxBit == `MUC_DATA_LAST) begin
            next_s.rxState = parityEn ? RX_PAR : RX_STOP;
          end
        end
      end
      RX_PAR: begin
        if (rxSample) begin
          if (rxLine != parBit(paritySel, s.rxPar)) begin
            next_s.parityErr = 1'b1;
          end
          next_s.rxState = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rxSample) begin
          if (!rxLine) begin
            next_s.frameErr = 1'b1;
          end
          next_s.rxCount = s.rxCount + 16'h0001;
          next_s.rxInMsg = 1'b1;
          next_s.rxIdle  = 8'h00;
          next_s.rxWord  = rxWordNew;
          if (s.rxCount[1:0] == `MUC_LANE_LAST) begin
            rxWe          = 1'b1;
            rxWd          = rxWordNew;
            next_s.rxWord = 32'h00000000;
            next_s.rxPtr  = s.rxPtr + 21'h1;
          end
          next_s.rxState = RX_IDLE;
        end
      end
      RX_FLUSH: begin
        rxWe           = 1'b1;
        next_s.rxWord  = 32'h00000000;
        next_s.rxPtr   = s.rxPtr + 21'h1;
        next_s.rxState = RX_STAT;
      end
      RX_STAT: begin
        rxWe = 1'b1;
        rxWa = s.rxBase[RX_AW-1:0];
        rxWd = {s.rxPtr[15:0], s.rxCount};
        next_s.rxBase      = s.rxPtr;
        next_s.rxPtr       = s.rxPtr + 21'h1;
        next_s.rxLastCount = s.rxCount;
        next_s.rxCount     = 16'h0000;
        next_s.rxInMsg     = 1'b0;
        next_s.rxIdle      = 8'h00;
        next_s.rxState     = RX_IDLE;
      end
      default: next_s.rxState = RX_IDLE;
    endcase

    // sticky status, a new event wins over the clear
    if (rxStatusClr) begin
      next_s.rxDone    = 1'b0;
      next_s.parityErr = s.parityErr & (next_s.parityErr != s.parityErr);
      next_s.frameErr  = s.frameErr & (next_s.frameErr != s.frameErr);
      if (s.rxState == RX_PAR && rxSample &&
          rxLine != parBit(paritySel, s.rxPar)) begin
        next_s.parityErr = 1'b1;
      end
      if (s.rxState == RX_STOP && rxSample && !rxLine) begin
        next_s.frameErr = 1'b1;
      end
    end
    if (s.rxState == RX_STAT) begin
      next_s.rxDone = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s          <= '0;
      s.txLine   <= `MUC_LINE_IDLE;
      s.rxSync   <= `MUC_SYNC_IDLE;
      s.lineSync <= `MUC_SYNC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // transmit ram: dma write first, then host write, host read
  always_ff @(posedge core_clk) begin
    if (dmaTxWe) begin
      txRam[dmaTxAddr] <= dmaTxWdata;
    end else if (hostTxWe) begin
      txRam[hostTxAddr] <= hostTxWdata;
    end
    hostTxRdata <= txRam[hostTxAddr];
  end

  // receive ram: receiver write first, then host write, reads
  always_ff @(posedge core_clk) begin
    if (rxWe) begin
      rxRam[rxWa] <= rxWd;
    end else if (hostRxWe) begin
      rxRam[hostRxAddr] <= hostRxWdata;
    end
    hostRxRdata <= rxRam[hostRxAddr];
    dmaRxRdata  <= rxRam[dmaRxAddr];
  end

endmodule

`default_nettype wire

// ---- tb/muc_channel_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module muc_channel_props (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // watched pins and status
  input wire logic        serTxOut,
  input wire logic        serTxOe,
  input wire logic        halfDuplex,
  input wire logic        txBusy,
  input wire logic        txDone,
  input wire logic        rxDone,
  input wire logic        rxStatusClr,
  input wire logic [15:0] rxMsgCount
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // line rests high outside characters
  property p_idle_high; !txBusy |-> serTxOut; endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("serial line low while idle");
  // start bit follows the take and lasts at least eight cycles
  property p_start; $rose(txBusy) |=> !serTxOut [*8]; endproperty
  a_start: assert property (p_start)
    else $error("start bit missing or short");
  // last stop bit is high up to the done pulse
  property p_stop; txDone |-> serTxOut && $past(serTxOut, 8); endproperty
  a_stop: assert property (p_stop)
    else $error("stop bit not high before done");
  // done only closes a busy transfer
  property p_done; $rose(txDone) |-> $past(txBusy); endproperty
  a_done: assert property (p_done)
    else $error("done without transfer");
  // full duplex always drives
  property p_oe_full; !halfDuplex |-> serTxOe; endproperty
  a_oe_full: assert property (p_oe_full)
    else $error("driver off in full duplex");
  // half duplex drives only while sending
  property p_oe_half; halfDuplex |-> serTxOe == txBusy; endproperty
  a_oe_half: assert property (p_oe_half)
    else $error("driver enable wrong in half duplex");
  // live byte counter steps by one
  property p_cnt;
    rxMsgCount != $past(rxMsgCount) && rxMsgCount != 16'h0000
      |-> rxMsgCount == $past(rxMsgCount) + 16'h0001;
  endproperty
  a_cnt: assert property (p_cnt)
    else $error("byte counter jumped");
  // done flag holds until cleared, then drops
  property p_sticky; rxDone && !rxStatusClr |=> rxDone; endproperty
  a_sticky: assert property (p_sticky)
    else $error("receive done lost");
  // a message closing in the clear cycle keeps it set
  property p_clr;
    rxStatusClr && rxDone |=> !rxDone ||
      (rxMsgCount == 16'h0000 && $past(rxMsgCount) != 16'h0000);
  endproperty
  a_clr: assert property (p_clr)
    else $error("receive done kept after clear");
  // main scenarios reached
  c_tx: cover property (txDone);
  c_rx: cover property (rxDone);
  c_half: cover property (halfDuplex && txBusy);
endmodule
bind muc_channel muc_channel_props u_props (.core_clk, .rst, .serTxOut,
  .serTxOe, .halfDuplex, .txBusy, .txDone, .rxDone, .rxStatusClr,
  .rxMsgCount);
`default_nettype wire

// ---- tb/muc_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module muc_remote #(
  parameter realtime BIT = 2560.0
) (
  // far side line pins
  output logic      remTx,
  input  wire logic lineIn,
  input  wire logic parOn
);
  logic [8:0] got[$];
  logic [8:0] sh;
  initial remTx = 1'b1;
  // sender: start, data lsb first, parity, two stops
  task automatic send(input logic [7:0] b, input logic p);
    remTx = 1'b0;
    #BIT;
    for (int i = 0; i < 8; i++) begin
      remTx = b[i];
      #BIT;
    end
    if (parOn) begin
      remTx = p;
      #BIT;
    end
    remTx = 1'b1;
    #(2 * BIT);
  endtask
  // receiver: sample mid bit after each falling start edge
  // without parity bit 8 holds the first stop bit
  always begin
    @(negedge lineIn);
    #(BIT / 2);
    sh = 9'h000;
    for (int i = 0; i < 9; i++) begin
      #BIT;
      sh[i] = lineIn;
    end
    got.push_back(sh);
    #BIT;
  end
endmodule
`default_nettype wire

// ---- tb/muc_channel_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module muc_channel_bench;
  import muc_pkg::*;
  logic        core_clk, rst, wordUartRef, halfDuplex, stopTwo, parityEn;
  logic        txEnable, rxEnable, rxStatusClr, hostTxWe, hostRxWe, dmaTxWe;
  logic        serTxOut, serTxOe, txBusy, txDone, rxDone, remTx, txLine;
  logic        rxParityErr, rxFrameErr;
  muc_par_t    paritySel;
  logic [7:0]  txStart, rxStart, hostTxAddr, hostRxAddr, dmaTxAddr, dmaRxAddr;
  logic [15:0] txByteCount, rxByteCount, rxMsgCount;
  logic [31:0] hostTxWdata, hostTxRdata, hostRxWdata, hostRxRdata;
  logic [31:0] dmaTxWdata, dmaRxRdata;
  int          err_total, check_count;
  // released transmit line is pulled up; remote drives it in half duplex
  assign txLine = serTxOe ? serTxOut : (halfDuplex ? remTx : 1'b1);
  muc_remote remote (.remTx(remTx), .lineIn(txLine), .parOn(parityEn));
  muc_channel #(.TX_AW(8), .RX_AW(8)) dut (.core_clk(core_clk), .rst(rst),
    .wordUartRef(wordUartRef), .serTxOut(serTxOut), .serTxOe(serTxOe),
    .serTxIn(txLine), .serRxIn(halfDuplex ? 1'b1 : remTx),
    .halfDuplex(halfDuplex), .stopTwo(stopTwo), .parityEn(parityEn),
    .paritySel(paritySel), .txEnable(txEnable), .txStart(txStart),
    .txByteCount(txByteCount), .txBusy(txBusy), .txDone(txDone),
    .rxEnable(rxEnable), .rxStart(rxStart), .rxStatusClr(rxStatusClr),
    .rxDone(rxDone), .rxParityErr(rxParityErr), .rxFrameErr(rxFrameErr),
    .rxByteCount(rxByteCount), .rxMsgCount(rxMsgCount),
    .hostTxWe(hostTxWe), .hostTxAddr(hostTxAddr),
    .hostTxWdata(hostTxWdata), .hostTxRdata(hostTxRdata),
    .hostRxWe(hostRxWe), .hostRxAddr(hostRxAddr),
    .hostRxWdata(hostRxWdata), .hostRxRdata(hostRxRdata),
    .dmaTxWe(dmaTxWe), .dmaTxAddr(dmaTxAddr), .dmaTxWdata(dmaTxWdata),
    .dmaRxAddr(dmaRxAddr), .dmaRxRdata(dmaRxRdata));
  // core clock 40 ns, link reference 160 ns (one bit = 2560 ns)
  always #20 core_clk = ~core_clk;
  always #80 wordUartRef = ~wordUartRef;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // bounded wait for txDone or rxDone
  task automatic wait_flag(input bit rx);
    for (int i = 0; i < 30000; i++) begin
      @(negedge core_clk);
      if (rx ? rxDone === 1'b1 : txDone === 1'b1) return;
    end
    err_total++;
    report_and_stop();
  endtask
  task automatic read_rx(input logic [7:0] a, input logic [31:0] e);
    hostRxAddr = a;
    @(negedge core_clk);
    chk(hostRxRdata, e);
  endtask
  task automatic clr;
    @(negedge core_clk);
    rxStatusClr = 1'b1;
    @(negedge core_clk);
    rxStatusClr = 1'b0;
    @(negedge core_clk);
    chk(rxDone, 1'b0);
  endtask
  task automatic tx_run(input logic [15:0] n);
    @(negedge core_clk);
    txByteCount = n;
    txEnable = 1'b1;
    @(negedge core_clk);
    chk(txBusy, 1'b1);
    wait_flag(1'b0);
    chk(txBusy, 1'b0);
    txEnable = 1'b0;
    @(negedge core_clk);
  endtask
  // host word access to both rams, dma write to transmit ram
  task automatic sc_ram;
    @(negedge core_clk);
    hostTxWe = 1'b1;
    hostTxAddr = 8'h02;
    hostTxWdata = 32'hA5C30F81;
    hostRxWe = 1'b1;
    hostRxAddr = 8'h40;
    hostRxWdata = 32'h5AA55AA5;
    @(negedge core_clk);
    hostTxWe = 1'b0;
    hostRxWe = 1'b0;
    dmaTxWe = 1'b1;
    dmaTxAddr = 8'h03;
    dmaTxWdata = 32'h7E5A3C01;
    @(negedge core_clk);
    dmaTxWe = 1'b0;
    hostTxAddr = 8'h03;
    @(negedge core_clk);
    chk(hostTxRdata, 32'h7E5A3C01);
    hostTxAddr = 8'h02;
    @(negedge core_clk);
    chk(hostTxRdata, 32'hA5C30F81);
    read_rx(8'h40, 32'h5AA55AA5);
  endtask
  // five bytes from word 2 in every parity mode, re-enabled each time
  task automatic sc_tx;
    logic [7:0] exp [5];
    logic       par;
    exp = '{8'h81, 8'h0F, 8'hC3, 8'hA5, 8'h01};
    txStart = 8'h02;
    for (int m = 0; m < 4; m++) begin
      paritySel = muc_par_t'(m);
      stopTwo = m[0];
      remote.got.delete();
      tx_run(16'h0005);
      chk(remote.got.size(), 5);
      for (int i = 0; i < 5 && i < remote.got.size(); i++) begin
        par = (m == 0) ? ~^exp[i] : (m == 1) ? ^exp[i] : (m == 2);
        chk(remote.got[i], {par, exp[i]});
      end
    end
  endtask
  // two messages stored back to back behind status words
  task automatic sc_rx;
    paritySel = PAR_EVEN;
    rxStart = 8'h04;
    @(negedge core_clk);
    rxEnable = 1'b1;
    for (int i = 1; i < 6; i++) remote.send(i[7:0], ^i[7:0]);
    @(negedge core_clk);
    chk(rxMsgCount, 16'h0005);
    wait_flag(1'b1);
    chk(rxByteCount, 16'h0005);
    chk(rxMsgCount, 16'h0000);
    chk(rxParityErr, 1'b0);
    chk(rxFrameErr, 1'b0);
    read_rx(8'h04, 32'h00070005);
    read_rx(8'h05, 32'h04030201);
    read_rx(8'h06, 32'h00000005);
    clr();
    remote.send(8'h11, 1'b0);
    remote.send(8'h22, 1'b0);
    wait_flag(1'b1);
    read_rx(8'h07, 32'h00090002);
    dmaRxAddr = 8'h08;
    @(negedge core_clk);
    chk(dmaRxRdata, 32'h00002211);
  endtask
  // wrong parity is flagged, held past the message, cleared on request
  task automatic sc_err;
    clr();
    paritySel = PAR_MARK;
    remote.send(8'h5A, 1'b0);
    wait_flag(1'b1);
    chk(rxParityErr, 1'b1);
    chk(rxFrameErr, 1'b0);
    clr();
    chk(rxParityErr, 1'b0);
    paritySel = PAR_EVEN;
  endtask
  // half duplex: receive from the transmit line, then send on it
  task automatic sc_half;
    clr();
    halfDuplex = 1'b1;
    rxEnable = 1'b0;
    rxStart = 8'h0A;
    @(negedge core_clk);
    rxEnable = 1'b1;
    chk(serTxOe, 1'b0);
    remote.send(8'h3C, 1'b0);
    wait_flag(1'b1);
    read_rx(8'h0A, 32'h000C0001);
    read_rx(8'h0B, 32'h0000003C);
    remote.got.delete();
    parityEn = 1'b0;
    paritySel = PAR_SPACE;
    tx_run(16'h0001);
    chk(remote.got.size(), 1);
    chk(remote.got[0], {1'b1, 8'h81});
  endtask
  initial begin
    core_clk = 0;
    wordUartRef = 0;
    rst = 1;
    {halfDuplex, stopTwo, txEnable, rxEnable, rxStatusClr} = '0;
    {hostTxWe, hostRxWe, dmaTxWe, txStart, rxStart, txByteCount} = '0;
    {hostTxAddr, hostRxAddr, dmaTxAddr, dmaRxAddr} = '0;
    {hostTxWdata, hostRxWdata, dmaTxWdata} = '0;
    parityEn = 1;
    paritySel = PAR_ODD;
    err_total = 0;
    check_count = 0;
    repeat (3) @(negedge core_clk);
    rst = 0;
    sc_ram();
    sc_tx();
    sc_rx();
    sc_err();
    sc_half();
    report_and_stop();
  end
endmodule
`default_nettype wire
